/* File: hw/adc_ctrl_regs.svh */
// control byte layout, sequencing counts and timing constants for the adc serial control
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// control byte field positions
`define ADC_START_BIT   7
`define ADC_SEL_HI_BIT  6
`define ADC_SEL_LO_BIT  4
`define ADC_CLK_BIT     3
`define ADC_REF_BIT     2
`define ADC_REFPD_BIT   1
`define ADC_PD_BIT      0

// received-bit counts that mark sequencing points, and result bits left after the msb
`define ADC_TRACK_CNT   4'h4
`define ADC_HOLD_CNT    4'h6
`define ADC_LAST_CNT    4'h7
`define ADC_OUT_BITS    4'h7

// successive-approximation steps and power-down allowance in sclk cycles
`define ADC_SAR_STEPS   8
`define ADC_PD_SCLK     10

// timing: core clock period and internal conversion step time
`define ADC_CLK_NS      100
`define ADC_STEP_NS     1000
`define ADC_STEP_CYC    ((`ADC_STEP_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

/* File: hw/adc_ctrl_pkg.sv */
// types for the adc serial control: link states and input configurations
package adc_ctrl_pkg;

   // link sequencing states, one-hot
   typedef enum logic [2:0] {
      ST_WAIT = 3'b001,   // hunting for the start bit
      ST_CTRL = 3'b010,   // shifting in the control byte
      ST_CONV = 3'b100    // converting and shifting the result out
   } link_state_t;

   // input configuration from the three select bits
   typedef enum logic [2:0] {
      CFG_B_COM_UNI = 3'h0,
      CFG_A_B_UNI   = 3'h1,
      CFG_B_A_UNI   = 3'h2,
      CFG_A_B_BIP   = 3'h3,
      CFG_B_A_BIP   = 3'h4,
      CFG_A_COM_BIP = 3'h5,
      CFG_VDD_MON   = 3'h6,
      CFG_A_COM_UNI = 3'h7
   } input_cfg_t;

endpackage

/* File: hw/adc_serial_conversion_control.sv */
// serial control byte intake, track/hold sequencing and sar conversion for a two-input adc
// Contract
// - serial input taken only while chip select low
// - output released to high impedance while deselected
// - input bits captured on serial clock rise
// - output bit changes on serial clock fall
// - external clock mode steps conversion per sclk
// - tracking starts on fall after bit 4
// - hold starts on fall after bit 6
// - all selects one: input a against common
// - track resumes immediately when conversion ends
// - select field decodes eight input configurations
// - at most one input switch closed
// - all modes come from the control byte
// - power down waits for conversion to finish
// - start bit 7, selects bits 6 to 4
// - bit 3 picks internal or external clock
// - leading zeros ignored, first one is start
// - result msb first, bipolar in twos complement
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_serial_conversion_control (
   input  wire logic       i_clk,          // core clock, paces internal conversions
   input  wire logic       i_rst,          // async reset, both domains
   input  wire logic       i_sclk,         // serial clock from host, link domain
   input  wire logic       i_cs_n,         // chip select, active low
   input  wire logic       i_din,          // serial data in
   output logic            o_dout,         // serial data out value
   output logic            o_dout_oe,      // serial data out drive enable
   input  wire logic       i_cmp_ext,      // comparator latched by sclk fall
   input  wire logic       i_cmp_int,      // comparator latched by i_clk
   output logic [7:0]      o_dac_code,     // trial code to the capacitive dac
   output logic [5:0]      o_input_switch, // {ref b, ref a, ref com, smp vdd, smp b, smp a}
   output logic            o_hold,         // track/hold in hold
   output logic            o_acquiring,    // acquisition window open
   output logic            o_ref_internal, // internal reference chosen
   output logic            o_ref_power_down, // reference powered down
   output logic            o_power_down,   // converter powered down
   output logic            o_bipolar       // bipolar coding in force
);

   adc_ctrl_pkg::link_state_t state;   // link sequencing state
   logic [7:0]  ctrl;                  // control byte shift register
   logic [3:0]  bitcnt;                // control bits received, start included
   logic        pd_req;                // power-down request held until done
   logic [2:0]  sel;                   // latched input select field
   logic        req_t;                 // conversion request toggle to core
   logic        ext_busy;              // external-clock conversion running
   logic [2:0]  ext_idx;               // bit under trial, external
   logic [7:0]  ext_res;               // bits decided, external
   logic [7:0]  out_sh;                // result shift register, internal mode
   logic [3:0]  out_cnt;               // result bits still to present
   logic        out_done;              // result fully presented
   logic        done_s1;               // done toggle sync, first stage
   logic        done_s2;               // done toggle sync, second stage
   logic        done_seen;             // last done toggle acted on
   logic        req_s1;                // request toggle sync, first stage
   logic        req_s2;                // request toggle sync, second stage
   logic        int_busy;              // internal-clock conversion running
   logic [2:0]  int_idx;               // bit under trial, internal
   logic [7:0]  int_work;              // bits decided, internal
   logic [7:0]  int_res;               // finished result, coded for output
   logic [4:0]  step_cnt;              // core cycles within one step
   logic        done_t;                // conversion done toggle to link
   logic        conv_start;            // hold edge of a live control byte
   logic [2:0]  smp_oh;                // sampled input switch, one-hot
   logic [2:0]  ref_oh;                // reference input switch, one-hot or all clear

   // driver only while selected; otherwise the pin floats
   assign o_dout_oe = !i_cs_n;

   // hold edge: sixth bit in, chip selected, no conversion pending
   // the core's done toggle is read only through its synchroniser here
   assign conv_start = !i_cs_n && state == adc_ctrl_pkg::ST_CTRL
                       && bitcnt == `ADC_HOLD_CNT && !ext_busy && (req_t == done_s2);

   // hold spans the running conversion; toggles differ only while core converts
   assign o_hold = ext_busy | (req_t ^ done_t);

   // input configuration decode, eight cases
   always_comb begin
      smp_oh    = 3'h1;
      ref_oh    = 3'h4;
      o_bipolar = 1'b0;
      case (adc_ctrl_pkg::input_cfg_t'(sel))
         adc_ctrl_pkg::CFG_B_COM_UNI: begin
            smp_oh = 3'h2;
         end
         adc_ctrl_pkg::CFG_A_B_UNI: begin
            ref_oh = 3'h2;
         end
         adc_ctrl_pkg::CFG_B_A_UNI: begin
            smp_oh = 3'h2;
            ref_oh = 3'h1;
         end
         adc_ctrl_pkg::CFG_A_B_BIP: begin
            ref_oh    = 3'h2;
            o_bipolar = 1'b1;
         end
         adc_ctrl_pkg::CFG_B_A_BIP: begin
            smp_oh    = 3'h2;
            ref_oh    = 3'h1;
            o_bipolar = 1'b1;
         end
         adc_ctrl_pkg::CFG_A_COM_BIP: begin
            o_bipolar = 1'b1;
         end
         adc_ctrl_pkg::CFG_VDD_MON: begin
            smp_oh = 3'h4;             // supply against ground, no ref switch
            ref_oh = 3'h0;
         end
         default: begin                // all ones: input a against common
            smp_oh = 3'h1;
            ref_oh = 3'h4;
         end
      endcase
   end

   // sampling switch while tracking, reference switch while holding
   assign o_input_switch = o_hold ? {ref_oh[1], ref_oh[0], ref_oh[2], 3'h0}
                                  : {3'h0, smp_oh};

   // trial code from whichever engine is running
   assign o_dac_code = ext_busy ? (ext_res | (8'h01 << ext_idx))
                     : int_busy ? (int_work | (8'h01 << int_idx)) : 8'h00;

   // control byte intake on sclk rise
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         state  <= adc_ctrl_pkg::ST_WAIT;
         ctrl   <= 8'h00;
         bitcnt <= 4'h0;
      end else if (!i_cs_n) begin
         case (state)
            adc_ctrl_pkg::ST_WAIT: begin
               if (i_din) begin                      // first one is start
                  ctrl   <= 8'h01;
                  bitcnt <= 4'h1;
                  state  <= adc_ctrl_pkg::ST_CTRL;
               end
            end
            adc_ctrl_pkg::ST_CTRL: begin
               ctrl   <= {ctrl[6:0], i_din};        // msb first
               bitcnt <= bitcnt + 4'h1;
               if (bitcnt == `ADC_LAST_CNT) begin
                  state <= adc_ctrl_pkg::ST_CONV;
               end
            end
            adc_ctrl_pkg::ST_CONV: begin
               if (out_done) begin                   // data ignored till here
                  state  <= adc_ctrl_pkg::ST_WAIT;
                  bitcnt <= 4'h0;
               end
            end
            default: begin
               state <= adc_ctrl_pkg::ST_WAIT;
            end
         endcase
      end
   end

   // power control; shutdown bit is active low and waits for the result
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         pd_req           <= 1'b0;
         o_ref_power_down <= 1'b0;
         o_power_down     <= 1'b0;
      end else if (!i_cs_n) begin
         if (state == adc_ctrl_pkg::ST_CTRL && bitcnt == `ADC_LAST_CNT) begin
            pd_req           <= !i_din;
            o_ref_power_down <= ctrl[0];
         end
         if (state == adc_ctrl_pkg::ST_WAIT && i_din) begin
            o_power_down <= 1'b0;                    // a start bit wakes the part
         end else if (state == adc_ctrl_pkg::ST_CONV && out_done) begin
            o_power_down <= pd_req;
         end
      end
   end

   // track/hold sequencing and mode latching on sclk fall
   always_ff @(negedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         sel            <= 3'h0;
         o_acquiring    <= 1'b0;
         o_ref_internal <= 1'b0;
         req_t          <= 1'b0;
      end else if (!i_cs_n && state == adc_ctrl_pkg::ST_CTRL
                   && bitcnt == `ADC_TRACK_CNT) begin
         o_acquiring <= 1'b1;
         sel         <= ctrl[2:0];
      end else if (conv_start) begin
         o_acquiring    <= 1'b0;
         o_ref_internal <= ctrl[0];
         if (ctrl[1]) begin                          // internal clock chosen
            req_t <= !req_t;                         // hand the sample to the core
         end
      end
   end

   // external-clock sar: one step per sclk fall, so the host sets the pace
   always_ff @(negedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         ext_busy <= 1'b0;
         ext_idx  <= 3'h0;
         ext_res  <= 8'h00;
      end else if (conv_start && !ctrl[1]) begin
         ext_busy <= 1'b1;
         ext_idx  <= 3'h7;
         ext_res  <= 8'h00;
      end else if (ext_busy) begin
         ext_res[ext_idx] <= i_cmp_ext;
         ext_idx          <= ext_idx - 3'h1;
         if (ext_idx == 3'h0) begin
            ext_busy <= 1'b0;                        // back to track at once
         end
      end
   end

   // done toggle from the core, two stages before the shift-out reads it; o_hold takes it raw
   always_ff @(negedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
      end else begin
         done_s1 <= done_t;
         done_s2 <= done_s1;
      end
   end

   // result shift-out on sclk fall, msb first
   always_ff @(negedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         o_dout    <= 1'b0;
         out_sh    <= 8'h00;
         out_cnt   <= 4'h0;
         out_done  <= 1'b0;
         done_seen <= 1'b0;
      end else if (conv_start) begin
         o_dout   <= 1'b0;
         out_done <= 1'b0;
      end else if (ext_busy) begin
         // decided bits leave as they are found; msb flipped for bipolar
         o_dout   <= (ext_idx == 3'h7) ? (i_cmp_ext ^ o_bipolar) : i_cmp_ext;
         out_done <= (ext_idx == 3'h0);
      end else if (done_s2 != done_seen) begin
         done_seen <= done_s2;
         o_dout    <= int_res[7];
         out_sh    <= {int_res[6:0], 1'b0};
         out_cnt   <= `ADC_OUT_BITS;
      end else if (out_cnt != 4'h0) begin
         o_dout   <= out_sh[7];
         out_sh   <= {out_sh[6:0], 1'b0};
         out_cnt  <= out_cnt - 4'h1;
         out_done <= (out_cnt == 4'h1);
      end
   end

   // request toggle into the core domain
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= req_t;
         req_s2 <= req_s1;
      end
   end

   // internal-clock sar; select bits stay put while the request is open
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         int_busy <= 1'b0;
         int_idx  <= 3'h0;
         int_work <= 8'h00;
         int_res  <= 8'h00;
         step_cnt <= 5'h00;
         done_t   <= 1'b0;
      end else if (!int_busy && req_s2 != done_t) begin
         int_busy <= 1'b1;
         int_idx  <= 3'h7;
         int_work <= 8'h00;
         step_cnt <= 5'h00;
      end else if (int_busy) begin
         if (step_cnt == 5'(`ADC_STEP_CYC - 1)) begin
            step_cnt          <= 5'h00;
            int_work[int_idx] <= i_cmp_int;
            int_idx           <= int_idx - 3'h1;
            if (int_idx == 3'h0) begin
               int_busy <= 1'b0;
               done_t   <= req_s2;                   // releases hold at once
               int_res  <= {int_work[7] ^ o_bipolar, int_work[6:1], i_cmp_int};
            end
         end else begin
            step_cnt <= step_cnt + 5'h01;
         end
      end
   end

   // expected shapes of a conversion
   sequence ext_run_s;
      ext_busy [*8];
   endsequence
   sequence ext_end_s;
      !ext_busy && !o_hold;
   endsequence

   dout_float_a: assert property (@(posedge i_clk) i_cs_n |-> !o_dout_oe)
      else $error("data out driven while deselected");

   cs_gate_a: assert property (@(posedge i_sclk) disable iff (i_rst)
      i_cs_n |=> $stable(state) && $stable(bitcnt) && $stable(ctrl))
      else $error("link advanced while deselected");

   start_hunt_a: assert property (@(posedge i_sclk) disable iff (i_rst)
      (state == adc_ctrl_pkg::ST_WAIT && !i_din) |=> state == adc_ctrl_pkg::ST_WAIT)
      else $error("zero bit taken as start");

   track_edge_a: assert property (@(negedge i_sclk) disable iff (i_rst)
      $rose(o_acquiring) |-> $past(bitcnt) == `ADC_TRACK_CNT)
      else $error("tracking began on the wrong edge");

   hold_edge_a: assert property (@(negedge i_sclk) disable iff (i_rst)
      $rose(ext_busy) |-> $past(bitcnt) == `ADC_HOLD_CNT && $past(o_acquiring))
      else $error("hold began on the wrong edge");

   ext_steps_a: assert property (@(negedge i_sclk) disable iff (i_rst)
      $rose(ext_busy) |-> ext_run_s ##1 ext_end_s)
      else $error("external conversion not eight steps");

   one_switch_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $onehot0(o_input_switch))
      else $error("more than one input switch closed");

   bip_msb_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(int_busy) |-> int_res[7] == (int_work[7] ^ o_bipolar))
      else $error("result msb coding wrong");

   int_return_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(int_busy) |-> done_t == req_s2)
      else $error("hold not released after conversion");

   pd_wait_a: assert property (@(posedge i_sclk) disable iff (i_rst)
      $rose(o_power_down) |-> $past(state) == adc_ctrl_pkg::ST_CONV && $past(out_done))
      else $error("powered down before conversion end");

   busy_ignore_a: assert property (@(posedge i_sclk) disable iff (i_rst)
      (state == adc_ctrl_pkg::ST_CONV && !out_done) |=> $stable(ctrl))
      else $error("input taken during conversion");

endmodule
`default_nettype wire

/* File: sim/adc_host_model.sv */
// host serial master model for the adc link, also standing in for the analog comparator
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
   output logic            o_sclk,   // serial clock, idles low between frames
   output logic            o_cs_n,   // chip select, active low
   output logic            o_din,    // serial data towards the device
   input  wire logic       i_dout,   // device data value
   input  wire logic       i_oe,     // device drive enable
   input  wire logic [7:0] i_dac,    // trial code under test
   input  wire logic [5:0] i_sw,     // input switch set
   input  wire logic       i_hold,   // track/hold in hold
   input  wire logic       i_acq,    // acquisition window
   output logic            o_cmp     // comparator: input at or above trial
);
   localparam real HALF = 7.5;       // half of the 15 ns link period
   logic [7:0]  analog;              // code the analog input stands at
   logic        pin;                 // data pin as the host sees it
   logic [31:0] snap_acq;            // per-bit snapshots, index = bit number from the start bit
   logic [31:0] snap_hold;
   logic [31:0] snap_dout;
   logic [5:0]  snap_sw [32];

   // a released pin shows the inverse so a stale value never reads as valid
   assign pin   = i_oe ? i_dout : ~i_dout;
   assign o_cmp = (analog >= i_dac);

   // idle levels at time zero
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b0;
      analog = 8'h00;
   end

   // clock pulses with the device deselected and din high
   task automatic idle_pulses(input int n);
      o_din = 1'b1;
      repeat (n) begin
         #(HALF) o_sclk = 1'b1;
         #(HALF) o_sclk = 1'b0;
      end
      o_din = 1'b0;
   endtask

   // one framed transfer: leading zeros, control byte, then post clocks
   task automatic frame(input logic [7:0] ctrl, input int zeros, input int post,
                        input int pause_ns);
      int k;
      int j;
      o_cs_n = 1'b0;
      for (k = 0; k < zeros + 8 + post; k++) begin
         j = k - zeros + 1;                    // bit number from the start bit
         if (k < zeros)
            o_din = 1'b0;                      // zeros before the start bit
         else if (j <= 8)
            o_din = ctrl[8 - j];               // control byte, msb first
         else
            o_din = (j <= 14);                 // ones while converting
         #(HALF - 1.0) o_sclk = 1'b1;
         #(HALF) o_sclk = 1'b0;
         if (j == 4 || j == 5)
            #600;                              // acquisition kept above 1 us
         if (j == 8)
            #(pause_ns);                       // host sets conversion pace
         #1;
         if (j >= 1) begin
            snap_acq[j]  = i_acq;
            snap_hold[j] = i_hold;
            snap_dout[j] = pin;
            snap_sw[j]   = i_sw;
         end
      end
      o_cs_n = 1'b1;
      o_din  = 1'b0;
      #(HALF);                                 // let the release settle before anyone looks
   endtask
endmodule
`default_nettype wire

/* File: sim/adc_serial_conversion_control_tb_top.sv */
// self-checking bench for the adc serial conversion control
`timescale 1ns/1ps
`default_nettype none
module adc_serial_conversion_control_tb_top;
   logic       i_clk;                  // core clock, 100 ns
   logic       i_rst;                  // async reset
   logic       sclk, cs_n, din, cmp;   // link and comparator from the host
   logic       dout, dout_oe, hold, acq, ref_int, ref_pd, pd, bip;
   logic [7:0] dac;                    // trial code
   logic [5:0] sw;                     // input switches
   int         fail_count;             // mismatches
   int         n_checks;               // comparisons made
   // expected switch sets per select code while tracking and while holding
   logic [5:0] smp_exp [8] = '{6'h02, 6'h01, 6'h02, 6'h01, 6'h02, 6'h01, 6'h04, 6'h01};
   logic [5:0] ref_exp [8] = '{6'h08, 6'h20, 6'h10, 6'h20, 6'h10, 6'h08, 6'h00, 6'h08};

   always #50 i_clk = ~i_clk;

   adc_serial_conversion_control dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
      .o_dout(dout), .o_dout_oe(dout_oe), .i_cmp_ext(cmp), .i_cmp_int(cmp),
      .o_dac_code(dac), .o_input_switch(sw), .o_hold(hold), .o_acquiring(acq),
      .o_ref_internal(ref_int), .o_ref_power_down(ref_pd), .o_power_down(pd),
      .o_bipolar(bip));

   adc_host_model host (
      .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout), .i_oe(dout_oe),
      .i_dac(dac), .i_sw(sw), .i_hold(hold), .i_acq(acq), .o_cmp(cmp));

   // one comparison, counted; unknowns never match
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("checks=%0d failures=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // result bits as the host read them after eight falls from the given one
   function automatic logic [7:0] result(input int first);
      logic [7:0] r;
      r = 8'h00;
      for (int j = first; j < first + 8; j++)
         r = {r[6:0], host.snap_dout[j]};
      return r;
   endfunction

   // idle state after reset, then clocks and din while deselected
   task automatic t_idle();
      check(dout_oe, 0);
      check(sw, 6'h02);
      host.idle_pulses(6);
      check(hold, 0);
      check(acq, 0);
      check(dout_oe, 0);
   endtask

   // every select code, leading zeros, ref bits and result coding
   task automatic t_configs();
      logic [2:0] s;
      logic [7:0] ctrl;
      logic       b;
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         b = (s == 3'h3 || s == 3'h4 || s == 3'h5);
         ctrl = {1'b1, s, 1'b0, s[0], s[1], 1'b1};
         host.analog = 8'h1f + 8'(i) * 8'h23;
         host.frame(ctrl, i, 10, 0);
         check(host.snap_acq[3], 0);
         check(host.snap_acq[4], 1);
         check(host.snap_hold[4], 0);
         check(host.snap_hold[6], 1);
         check(host.snap_acq[6], 0);
         check(host.snap_sw[5], smp_exp[i]);
         check(host.snap_sw[7], ref_exp[i]);
         for (int j = 1; j <= 18; j++)
            check($onehot0(host.snap_sw[j]), 1);
         check(result(7), host.analog ^ {b, 7'h00});
         check(bip, b);
         check({ref_int, ref_pd, pd}, {s[0], s[1], 1'b0});
         check(host.snap_hold[15], 0);
         check({hold, acq}, 0);
         check(dout_oe, 0);
      end
   endtask

   // external clock: conversion stalls while the host stalls
   task automatic t_ext_pause();
      host.analog = 8'hc3;
      host.frame(8'hf1, 0, 10, 20000);
      check(host.snap_hold[8], 1);
      check(result(7), 8'hc3);
   endtask

   // shutdown bit cleared powers down after the conversion, start bit wakes
   task automatic t_power_down();
      host.frame(8'hf0, 0, 10, 0);
      check(pd, 1);
      host.frame(8'hf1, 0, 10, 0);
      check(pd, 0);
   endtask

   // internal clock: conversion completes with the link clock stopped
   task automatic t_internal();
      host.analog = 8'h5a;
      host.frame(8'hf9, 0, 14, 100000);
      check(host.snap_hold[7], 1);
      check(host.snap_hold[8], 0);
      check(result(11), 8'h5a);
      check(hold, 0);
   endtask

   // main sequence: reset held 16 core cycles, then the scenarios
   initial begin
      i_clk = 1'b0;
      i_rst = 1'b1;
      fail_count = 0;
      n_checks = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      t_idle();
      t_configs();
      t_ext_pause();
      t_power_down();
      t_internal();
      summarize();
   end

   // watchdog well past the expected run of about 140 us
   initial begin
      #2000000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
